//--- src/pasr_pkg.sv
// Package for the auto-negotiation / shadow status register bank.
// Assumes one 250 MHz core clock shared by every user of these constants.
package pasr_pkg;

  // ----------------------------------------------------------------
  // Register addresses on the management serial port
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_AUX    = 5'h18;
  localparam logic [4:0] ADDR_SHADOW = 5'h1B;
  localparam logic [4:0] ADDR_SH_EN  = 5'h1F;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AUX_HCD_LO   = 11;
  localparam int AUX_HCD_HI   = 15;
  localparam int AUX_T4_IDX   = 3;  // Position of the T4 flag inside the 5-bit field
  localparam int AUX_RESTART  = 8;
  localparam int AUX_PASS_100 = 7;
  localparam int AUX_PASS_10  = 6;
  localparam int AUX_COMPLETE = 5;
  localparam int AUX_ACK      = 4;
  localparam int AUX_ABILITY  = 3;
  localparam int AUX_SUPER    = 2;
  localparam int SHEN_BIT     = 7;
  localparam int SH_MLT3_OK   = 15;
  localparam int SH_CABLE_LO  = 12;
  localparam int SH_CABLE_HI  = 14;
  localparam int SH_RES11     = 11;
  localparam int SH_LED_TEST  = 10;
  localparam int SH_DLOCK     = 9;
  localparam int SH_FALSE_CAR = 8;
  localparam int SH_BAD_ESD   = 7;
  localparam int SH_RX_ERR    = 6;
  localparam int SH_LOCK_ERR  = 4;
  localparam int SH_MLT3_ERR  = 3;
  localparam int SH_RES_LO    = 0;
  localparam int SH_RES_HI    = 2;

  // ----------------------------------------------------------------
  // Reset values and fixed figures
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_WORD     = 16'h0000;
  localparam logic [4:0]  T4_BEST_ABILITY_FLAG_MASK  = 5'h17;
  localparam int          LED_SPEEDUP  = 8192;

  // ----------------------------------------------------------------
  // Management frame figures
  // ----------------------------------------------------------------
  localparam logic [5:0] MDIO_PRE_LEN   = 6'h20;
  localparam logic [5:0] MDIO_ADDR_LAST = 6'h04;
  localparam logic [5:0] MDIO_OP_LAST   = 6'h01;
  localparam logic [5:0] MDIO_DATA_LAST = 6'h0F;
  localparam logic [1:0] MDIO_OP_RD     = 2'h2;
  localparam logic [1:0] MDIO_OP_WR     = 2'h1;

  // ----------------------------------------------------------------
  // Data interface clock rates (kHz) and derived tick periods
  // ----------------------------------------------------------------
  localparam int CORE_KHZ   = 250000;
  localparam int MII10_KHZ  = 2500;
  localparam int MII100_KHZ = 25000;
  localparam int RMII_KHZ   = 50000;
  localparam logic [6:0] TICK_MII10  = 7'(CORE_KHZ / MII10_KHZ - 1);
  localparam logic [6:0] TICK_MII100 = 7'(CORE_KHZ / MII100_KHZ - 1);
  localparam logic [6:0] TICK_RMII   = 7'(CORE_KHZ / RMII_KHZ - 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MS_IDLE  = 3'b000,
    MS_START = 3'b001,
    MS_OP    = 3'b010,
    MS_PHY   = 3'b011,
    MS_REG   = 3'b100,
    MS_TA    = 3'b101,
    MS_DATA  = 3'b110
  } pasr_mstate_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pasr_mreq_t;

  typedef struct packed {
    logic       en;
    logic       pass_100;
    logic       pass_10;
    logic       done;
    logic       ack_exit;
    logic       ability_state;
    logic       hcd_load;
    logic       full_handshake;
    logic       link_fault;
    logic [4:0] best_shared_ability;
  } pasr_an_stat_t;

  typedef struct packed {
    logic       mlt3_ok;
    logic       tx100;
    logic [2:0] cable_len;
    logic       descr_lock;
    logic       false_carrier;
    logic       bad_esd;
    logic       rx_err;
    logic       lock_err;
    logic       mlt3_err;
  } pasr_rx_stat_t;

endpackage : pasr_pkg

//--- src/pasr_mdio_serial.sv
// Serial management frame engine: preamble, start, opcode, addresses,
// turnaround and 16 data bits. Assumes MDC is far slower than core_clk.
`timescale 1ns/1ns
`default_nettype none
module pasr_mdio_serial #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              mdc,
  input  wire logic              mdio_in,
  output logic                   mdio_out,
  output logic                   mdio_oe_n,
  output pasr_pkg::pasr_mreq_t   req,
  input  wire logic [15:0]       rdata
);

  typedef struct packed {
    logic                 mdc_s1;
    logic                 mdc_s2;
    logic                 mdc_s3;
    logic                 mdio_s1;
    logic                 mdio_s2;
    pasr_pkg::pasr_mstate_t st;
    logic [5:0]           cnt;
    logic [1:0]           op;
    logic [4:0]           phyad;
    logic [4:0]           regad;
    logic [15:0]          shreg;
    logic                 drive;
    logic                 dout;
    pasr_pkg::pasr_mreq_t req;
  } pasr_ser_t;

  pasr_ser_t s_ff;
  pasr_ser_t nxt_s;
  logic      rise;
  logic      bit_in;
  logic      is_rd;

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  // Edge comes from the second and third sync stages, bit from the second
  assign rise   = s_ff.mdc_s2 & ~s_ff.mdc_s3;
  assign bit_in = s_ff.mdio_s2;
  assign is_rd  = (s_ff.op == pasr_pkg::MDIO_OP_RD) && (s_ff.phyad == PHY_ADDR);

  always_comb begin
    nxt_s         = s_ff;
    nxt_s.mdc_s1  = mdc;
    nxt_s.mdc_s2  = s_ff.mdc_s1;
    nxt_s.mdc_s3  = s_ff.mdc_s2;
    nxt_s.mdio_s1 = mdio_in;
    nxt_s.mdio_s2 = s_ff.mdio_s1;
    nxt_s.req.rd  = 1'b0;
    nxt_s.req.wr  = 1'b0;
    if (rise) begin
      case (s_ff.st)
        pasr_pkg::MS_IDLE: begin
          if (bit_in) begin
            if (s_ff.cnt != pasr_pkg::MDIO_PRE_LEN) nxt_s.cnt = s_ff.cnt + 6'h01;
          end else begin
            // A zero after a full preamble is the first start bit
            if (s_ff.cnt == pasr_pkg::MDIO_PRE_LEN) nxt_s.st = pasr_pkg::MS_START;
            nxt_s.cnt = '0;
          end
        end
        pasr_pkg::MS_START: begin
          nxt_s.st  = bit_in ? pasr_pkg::MS_OP : pasr_pkg::MS_IDLE;
          nxt_s.cnt = '0;
        end
        pasr_pkg::MS_OP: begin
          nxt_s.op  = {s_ff.op[0], bit_in};
          nxt_s.cnt = s_ff.cnt + 6'h01;
          if (s_ff.cnt == pasr_pkg::MDIO_OP_LAST) begin
            nxt_s.st  = pasr_pkg::MS_PHY;
            nxt_s.cnt = '0;
          end
        end
        pasr_pkg::MS_PHY: begin
          nxt_s.phyad = {s_ff.phyad[3:0], bit_in};
          nxt_s.cnt   = s_ff.cnt + 6'h01;
          if (s_ff.cnt == pasr_pkg::MDIO_ADDR_LAST) begin
            nxt_s.st  = pasr_pkg::MS_REG;
            nxt_s.cnt = '0;
          end
        end
        pasr_pkg::MS_REG: begin
          nxt_s.regad = {s_ff.regad[3:0], bit_in};
          nxt_s.cnt   = s_ff.cnt + 6'h01;
          if (s_ff.cnt == pasr_pkg::MDIO_ADDR_LAST) begin
            nxt_s.st       = pasr_pkg::MS_TA;
            nxt_s.cnt      = '0;
            nxt_s.req.addr = {s_ff.regad[3:0], bit_in};
            nxt_s.req.rd   = is_rd;
          end
        end
        pasr_pkg::MS_TA: begin
          if (s_ff.cnt == 6'h00) begin
            nxt_s.cnt = 6'h01;
            if (is_rd) begin
              nxt_s.drive = 1'b1;
              nxt_s.dout  = 1'b0;
              nxt_s.shreg = rdata;
            end
          end else begin
            nxt_s.st  = pasr_pkg::MS_DATA;
            nxt_s.cnt = '0;
            if (is_rd) begin
              nxt_s.dout  = s_ff.shreg[15];
              nxt_s.shreg = {s_ff.shreg[14:0], 1'b0};
            end
          end
        end
        pasr_pkg::MS_DATA: begin
          nxt_s.cnt = s_ff.cnt + 6'h01;
          if (is_rd) begin
            nxt_s.dout  = s_ff.shreg[15];
            nxt_s.shreg = {s_ff.shreg[14:0], 1'b0};
          end else begin
            nxt_s.shreg = {s_ff.shreg[14:0], bit_in};
          end
          if (s_ff.cnt == pasr_pkg::MDIO_DATA_LAST) begin
            // Release the line after the last read bit was sampled
            nxt_s.drive     = 1'b0;
            nxt_s.st        = pasr_pkg::MS_IDLE;
            nxt_s.cnt       = '0;
            nxt_s.req.wr    = (s_ff.op == pasr_pkg::MDIO_OP_WR) && (s_ff.phyad == PHY_ADDR);
            nxt_s.req.wdata = {s_ff.shreg[14:0], bit_in};
          end
        end
        default: begin
          nxt_s.st  = pasr_pkg::MS_IDLE;
          nxt_s.cnt = '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign req       = s_ff.req;
  assign mdio_out  = s_ff.dout;
  assign mdio_oe_n = ~s_ff.drive;

endmodule : pasr_mdio_serial
`default_nettype wire

//--- src/pasr_regs.sv
// Auxiliary negotiation status/control and shadow status registers,
// reached over the serial management port.
// Assumes negotiation and receive status come from logic on core_clk.
`timescale 1ns/1ns
`default_nettype none
module pasr_regs #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   mdc,
  input  wire logic                   mdio_in,
  output logic                        mdio_out,
  output logic                        mdio_oe_n,
  input  wire pasr_pkg::pasr_an_stat_t an_stat,
  input  wire pasr_pkg::pasr_rx_stat_t rx_stat,
  input  wire logic                   basic_isolate,
  input  wire logic                   coding_pulse_off,
  input  wire logic                   rmii_mode,
  input  wire logic                   speed_100,
  output logic                        an_restart,
  output logic                        mii_isolate,
  output logic                        link_pulse_off,
  output logic                        led_speedup,
  output logic                        ref_tick
);

  typedef struct packed {
    logic [4:0]  best_shared_ability;
    logic        complete;
    logic        ack;
    logic        super_iso;
    logic        restart_p;
    logic        shadow_en;
    logic        led_fast;
    logic        res11;
    logic [2:0]  res_lo;
    logic [4:0]  latch;      // false carrier, bad ESD, rx err, lock err, MLT3 err
    logic [15:0] rdata;
    logic [6:0]  tick_cnt;
    logic        tick;
  } pasr_reg_t;

  pasr_reg_t            r_ff;
  pasr_reg_t            nxt_r;
  pasr_pkg::pasr_mreq_t req;
  logic [15:0]          aux_word;
  logic [15:0]          sh_word;
  logic [4:0]           events;
  logic                 sh_access;
  logic                 sh_read;
  logic                 an_clear;
  logic [6:0]           tick_last;

  // ----------------------------------------------------------------
  // Serial port engine
  // ----------------------------------------------------------------
  pasr_mdio_serial #(
    .PHY_ADDR (PHY_ADDR)
  ) u_ser (
    .core_clk  (core_clk),
    .rst       (rst),
    .mdc       (mdc),
    .mdio_in   (mdio_in),
    .mdio_out  (mdio_out),
    .mdio_oe_n (mdio_oe_n),
    .req       (req),
    .rdata     (r_ff.rdata)
  );

  // ----------------------------------------------------------------
  // Read words
  // ----------------------------------------------------------------
  // Builds the auxiliary word from live status and held bits
  function automatic logic [15:0] aux_compose(input pasr_reg_t r,
                                              input pasr_pkg::pasr_an_stat_t a);
    logic [15:0] w;
    w = pasr_pkg::RST_WORD;
    w[pasr_pkg::AUX_HCD_HI:pasr_pkg::AUX_HCD_LO] = r.best_shared_ability & pasr_pkg::T4_BEST_ABILITY_FLAG_MASK;
    w[pasr_pkg::AUX_PASS_100] = a.pass_100;
    w[pasr_pkg::AUX_PASS_10]  = a.pass_10;
    w[pasr_pkg::AUX_COMPLETE] = r.complete & a.en;
    w[pasr_pkg::AUX_ACK]      = r.ack;
    w[pasr_pkg::AUX_ABILITY]  = a.ability_state & a.en;
    w[pasr_pkg::AUX_SUPER]    = r.super_iso;
    return w;
  endfunction : aux_compose

  assign aux_word = aux_compose(r_ff, an_stat);

  // Shadow word: live status plus latched flags
  always_comb begin
    sh_word = pasr_pkg::RST_WORD;
    // clean MLT3 only in 100 Mb/s twisted pair
    sh_word[pasr_pkg::SH_MLT3_OK] = rx_stat.mlt3_ok & rx_stat.tx100;
    sh_word[pasr_pkg::SH_CABLE_HI:pasr_pkg::SH_CABLE_LO] = rx_stat.cable_len;
    sh_word[pasr_pkg::SH_RES11]    = r_ff.res11;
    sh_word[pasr_pkg::SH_LED_TEST] = r_ff.led_fast;
    sh_word[pasr_pkg::SH_DLOCK]     = rx_stat.descr_lock;
    sh_word[pasr_pkg::SH_FALSE_CAR] = r_ff.latch[4];
    sh_word[pasr_pkg::SH_BAD_ESD]   = r_ff.latch[3];
    sh_word[pasr_pkg::SH_RX_ERR]    = r_ff.latch[2];
    sh_word[pasr_pkg::SH_LOCK_ERR]  = r_ff.latch[1];
    sh_word[pasr_pkg::SH_MLT3_ERR]  = r_ff.latch[0];
    sh_word[pasr_pkg::SH_RES_HI:pasr_pkg::SH_RES_LO] = r_ff.res_lo;
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // shadow overlay only while enable is set
  assign sh_access = (req.rd | req.wr) && (req.addr == pasr_pkg::ADDR_SHADOW) && r_ff.shadow_en;
  assign sh_read   = sh_access & req.rd;
  assign events    = {rx_stat.false_carrier, rx_stat.bad_esd, rx_stat.rx_err,
                      rx_stat.lock_err, rx_stat.mlt3_err};
  assign an_clear  = r_ff.restart_p;
  assign tick_last = rmii_mode ? pasr_pkg::TICK_RMII :
                     (speed_100 ? pasr_pkg::TICK_MII100 : pasr_pkg::TICK_MII10);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_r           = r_ff;
    nxt_r.restart_p = 1'b0;

    // Read data snapshot; flags are cleared only after the capture
    if (req.rd) begin
      case (req.addr)
        pasr_pkg::ADDR_AUX:    nxt_r.rdata = aux_word;
        pasr_pkg::ADDR_SHADOW: nxt_r.rdata = r_ff.shadow_en ? sh_word : pasr_pkg::RST_WORD;
        pasr_pkg::ADDR_SH_EN: begin
          nxt_r.rdata                   = pasr_pkg::RST_WORD;
          nxt_r.rdata[pasr_pkg::SHEN_BIT] = r_ff.shadow_en;
        end
        default:               nxt_r.rdata = pasr_pkg::RST_WORD;
      endcase
    end

    // Writes
    if (req.wr) begin
      case (req.addr)
        pasr_pkg::ADDR_AUX: begin
          nxt_r.super_iso = req.wdata[pasr_pkg::AUX_SUPER];
          nxt_r.restart_p = req.wdata[pasr_pkg::AUX_RESTART] & an_stat.en;
        end
        pasr_pkg::ADDR_SHADOW: begin
          if (r_ff.shadow_en) begin
            nxt_r.led_fast = req.wdata[pasr_pkg::SH_LED_TEST];
            nxt_r.res11    = req.wdata[pasr_pkg::SH_RES11];
            nxt_r.res_lo   = req.wdata[pasr_pkg::SH_RES_HI:pasr_pkg::SH_RES_LO];
          end
        end
        pasr_pkg::ADDR_SH_EN: nxt_r.shadow_en = req.wdata[pasr_pkg::SHEN_BIT];
        default: ;
      endcase
    end

    // enable drops after one shadow access
    if (sh_access) nxt_r.shadow_en = 1'b0;

    // latch high, read clears but new event wins
    nxt_r.latch = events | (r_ff.latch & ~{5{sh_read}});

    // ability bits accumulate from full handshakes only
    if (an_clear) begin
      nxt_r.best_shared_ability = '0;
    end else if (an_stat.hcd_load && an_stat.full_handshake) begin
      nxt_r.best_shared_ability = r_ff.best_shared_ability | (an_stat.best_shared_ability & pasr_pkg::T4_BEST_ABILITY_FLAG_MASK);
    end

    // complete held until restart, link fault or negotiation disable
    if (an_clear || an_stat.link_fault || !an_stat.en) begin
      nxt_r.complete = 1'b0;
    end else if (an_stat.done) begin
      nxt_r.complete = 1'b1;
    end

    if (an_clear) begin
      nxt_r.ack = 1'b0;
    end else if (an_stat.ack_exit) begin
      nxt_r.ack = 1'b1;
    end

    nxt_r.tick = 1'b0;
    if (r_ff.tick_cnt >= tick_last) begin
      nxt_r.tick_cnt = '0;
      nxt_r.tick     = 1'b1;
    end else begin
      nxt_r.tick_cnt = r_ff.tick_cnt + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset; every field, including results, starts at zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign an_restart     = r_ff.restart_p;
  // isolate and pulse mute, either source
  assign mii_isolate    = r_ff.super_iso | basic_isolate;
  assign link_pulse_off = r_ff.super_iso | coding_pulse_off;
  assign led_speedup    = r_ff.led_fast;
  assign ref_tick       = r_ff.tick;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_restart_write;
    req.wr && req.addr == pasr_pkg::ADDR_AUX && req.wdata[pasr_pkg::AUX_RESTART] && an_stat.en;
  endsequence

  sequence s_shadow_read;
    req.rd && req.addr == pasr_pkg::ADDR_SHADOW && r_ff.shadow_en;
  endsequence

  // Tick period only holds while the mode inputs sit still
  sequence s_mode_held;
    $stable(speed_100) && $stable(rmii_mode);
  endsequence

  a_restart_pulse: assert property (
    s_restart_write |=> an_restart ##1 !an_restart)
    else $error("restart pulse not one cycle");

  a_hcd_restart_clr: assert property (
    an_restart |=> r_ff.best_shared_ability == 5'h00 && !r_ff.ack)
    else $error("ability or ack not cleared by restart");

  a_t4_zero: assert property (
    !aux_word[pasr_pkg::AUX_HCD_LO + pasr_pkg::AUX_T4_IDX])
    else $error("T4 flag set");

  a_complete_off: assert property (
    !an_stat.en |=> !aux_word[pasr_pkg::AUX_COMPLETE])
    else $error("complete set while disabled");

  // Link fault drops complete at once
  a_complete_fault: assert property (
    an_stat.link_fault |=> !r_ff.complete)
    else $error("complete kept over link fault");

  // Restart refused while negotiation is off
  a_restart_needs_en: assert property (
    req.wr && req.addr == pasr_pkg::ADDR_AUX && !an_stat.en |=> !an_restart)
    else $error("restart while disabled");

  a_parallel_hold: assert property (
    an_stat.hcd_load && !an_stat.full_handshake && !an_clear |=> $stable(r_ff.best_shared_ability))
    else $error("ability bits changed without full handshake");

  a_ack_hold: assert property (
    an_stat.ack_exit && !an_clear |=> r_ff.ack)
    else $error("ack not set on exit");

  a_shadow_selfclr: assert property (
    s_shadow_read ##1 !(req.wr && req.addr == pasr_pkg::ADDR_SH_EN) |-> !r_ff.shadow_en)
    else $error("shadow enable did not self-clear");

  a_latch_readclr: assert property (
    s_shadow_read ##0 (events == 5'h00) |=> r_ff.latch == 5'h00)
    else $error("latched flags not cleared on read");

  a_latch_set: assert property (
    events[2] |=> r_ff.latch[2] ##1 (r_ff.latch[2] || $past(sh_read)))
    else $error("rx error flag not latched");

  // A latched flag only drops on a shadow read
  a_latch_hold: assert property (
    r_ff.latch[4] && !sh_read |=> r_ff.latch[4])
    else $error("false carrier flag lost");

  // Enabled reads of 0x1B return the shadow word
  a_shadow_redirect: assert property (
    s_shadow_read |=> r_ff.rdata == $past(sh_word))
    else $error("shadow word not returned");

  // Without the enable 0x1B is the plain register
  a_plain_addr_read: assert property (
    req.rd && req.addr == pasr_pkg::ADDR_SHADOW && !r_ff.shadow_en
      |=> r_ff.rdata == pasr_pkg::RST_WORD)
    else $error("shadow word leaked");

  a_isolate_map: assert property (
    r_ff.super_iso |-> mii_isolate && link_pulse_off)
    else $error("super isolate not applied");

  // Ten cycles per tick while the 25 MHz mode holds
  a_tick_period: assert property (
    ref_tick && !rmii_mode && speed_100 ##1 s_mode_held [*8] ##1 s_mode_held
      |=> ref_tick)
    else $error("25 MHz tick period wrong");

endmodule : pasr_regs
`default_nettype wire

//--- dv/pasr_sta_model.sv
// Station manager model: sends management frames to the register bank.
// Assumes a 250 MHz core clock; MDC is 1/21 of it and stands low between frames.
`timescale 1ns/1ns
`default_nettype none
module pasr_sta_model #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input  wire logic core_clk,
  output logic      mdc,
  output logic      mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe_n
);
  logic m_oe;
  logic m_val;

  // Shared wire with pull-up, so a released line reads one
  assign mdio_in = !mdio_oe_n ? mdio_out : (m_oe ? m_val : 1'b1);

  initial begin
    mdc = 1'b0;
    m_oe = 1'b0;
    m_val = 1'b1;
  end

  // Whole frame, fresh preamble each time
  task automatic xfer(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rdat);
    logic [45:0] hdr;
    hdr = {32'hFFFF_FFFF, 2'b01, rd ? pasr_pkg::MDIO_OP_RD : pasr_pkg::MDIO_OP_WR,
           PHY_ADDR, ra};
    rdat = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      @(negedge core_clk);
      mdc = 1'b0;
      // Device bit settled since last rise; take it before it moves
      if (rd && i >= 48) rdat = {rdat[14:0], mdio_in};
      m_oe = !(rd && i >= 46);
      m_val = (i < 46) ? hdr[45-i] : ((i < 48) ? (i == 46) : wd[63-i]);
      repeat (10) @(negedge core_clk);
      mdc = 1'b1;
      repeat (10) @(negedge core_clk);
    end
    mdc = 1'b0;
    m_oe = 1'b0;
  endtask : xfer
endmodule : pasr_sta_model
`default_nettype wire

//--- dv/pasr_regs_tb.sv
// Testbench for the negotiation and shadow status register bank.
// Assumes the station manager model drives all management frames.
`timescale 1ns/1ns
`default_nettype none
module pasr_regs_tb;
  logic                    core_clk;
  logic                    rst;
  logic                    mdc;
  logic                    mdio_in;
  logic                    mdio_out;
  logic                    mdio_oe_n;
  pasr_pkg::pasr_an_stat_t an;
  pasr_pkg::pasr_rx_stat_t rx;
  logic                    basic_isolate;
  logic                    coding_pulse_off;
  logic                    rmii_mode;
  logic                    speed_100;
  logic                    an_restart;
  logic                    mii_isolate;
  logic                    link_pulse_off;
  logic                    led_speedup;
  logic                    ref_tick;
  int                      fails = 0;
  int                      samples_checked = 0;
  int                      restarts = 0;

  pasr_regs u_pasr_regs (.core_clk(core_clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .an_stat(an), .rx_stat(rx),
    .basic_isolate(basic_isolate), .coding_pulse_off(coding_pulse_off),
    .rmii_mode(rmii_mode), .speed_100(speed_100), .an_restart(an_restart),
    .mii_isolate(mii_isolate), .link_pulse_off(link_pulse_off),
    .led_speedup(led_speedup), .ref_tick(ref_tick));
  pasr_sta_model u_pasr_sta_model (.core_clk(core_clk), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n));

  // 250 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Restart pulses counted so a double pulse shows up
  always @(posedge core_clk) if (an_restart === 1'b1) restarts++;

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] v;
    u_pasr_sta_model.xfer(1'b1, a, 16'h0000, v);
    chk(v, e);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] v;
    u_pasr_sta_model.xfer(1'b0, a, d, v);
  endtask : wr

  task automatic t_reset(input logic [15:0] aux_exp);
    // Load ability bits first, when full_handshake is already set, so the reset has something to clear
    @(negedge core_clk);
    an.hcd_load = 1'b1;
    @(negedge core_clk);
    an.hcd_load = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    rd(pasr_pkg::ADDR_AUX, aux_exp);
    rd(pasr_pkg::ADDR_SH_EN, 16'h0000);
    chk({15'h0000, led_speedup}, 16'h0000);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_neg();
    @(negedge core_clk);
    an.en = 1'b1;
    an.ability_state = 1'b1;
    an.best_shared_ability = 5'h08;
    an.hcd_load = 1'b1;
    @(negedge core_clk);
    an.hcd_load = 1'b0;
    rd(pasr_pkg::ADDR_AUX, 16'h0008);
    an.ability_state = 1'b0;
    an.best_shared_ability = 5'h1F;
    an.full_handshake = 1'b1;
    {an.hcd_load, an.ack_exit, an.done, an.pass_100} = 4'hF;
    @(negedge core_clk);
    {an.hcd_load, an.ack_exit, an.done} = 3'h0;
    rd(pasr_pkg::ADDR_AUX, 16'hB8B0);
    // Link fault drops complete only
    @(negedge core_clk);
    an.link_fault = 1'b1;
    @(negedge core_clk);
    an.link_fault = 1'b0;
    rd(pasr_pkg::ADDR_AUX, 16'hB890);
    // Restart clears the results, pass level stays
    wr(pasr_pkg::ADDR_AUX, 16'h0100);
    chk(16'(restarts), 16'h0001);
    rd(pasr_pkg::ADDR_AUX, 16'h0080);
    $display("t_neg done");
  endtask : t_neg

  task automatic t_iso();
    // Restart is refused while negotiation is off
    an.en = 1'b0;
    wr(pasr_pkg::ADDR_AUX, 16'h0104);
    chk(16'(restarts), 16'h0001);
    chk({14'h0000, mii_isolate, link_pulse_off}, 16'h0003);
    rd(pasr_pkg::ADDR_AUX, 16'h0084);
    wr(pasr_pkg::ADDR_AUX, 16'h0000);
    chk({14'h0000, mii_isolate, link_pulse_off}, 16'h0000);
    // Outside isolate sources reach the outputs too
    {basic_isolate, coding_pulse_off} = 2'h3;
    @(posedge core_clk);
    chk({14'h0000, mii_isolate, link_pulse_off}, 16'h0003);
    @(negedge core_clk);
    {basic_isolate, coding_pulse_off} = 2'h0;
    $display("t_iso done");
  endtask : t_iso

  task automatic t_shadow();
    @(negedge core_clk);
    {rx.mlt3_ok, rx.tx100, rx.cable_len, rx.descr_lock} = 6'h3F;
    {rx.false_carrier, rx.rx_err} = 2'h3;
    @(negedge core_clk);
    {rx.false_carrier, rx.rx_err} = 2'h0;
    wr(pasr_pkg::ADDR_SH_EN, 16'h0080);
    rd(pasr_pkg::ADDR_SH_EN, 16'h0080);
    wr(pasr_pkg::ADDR_SHADOW, 16'h0405);
    chk({15'h0000, led_speedup}, 16'h0001);
    rd(pasr_pkg::ADDR_SH_EN, 16'h0000);
    rd(pasr_pkg::ADDR_SHADOW, 16'h0000);
    wr(pasr_pkg::ADDR_SH_EN, 16'h0080);
    rd(pasr_pkg::ADDR_SHADOW, 16'hF745);
    wr(pasr_pkg::ADDR_SH_EN, 16'h0080);
    rd(pasr_pkg::ADDR_SHADOW, 16'hF605);
    $display("t_shadow done");
  endtask : t_shadow

  task automatic t_tick(input logic rm, input logic sp, input logic [15:0] per);
    int n;
    @(negedge core_clk);
    rmii_mode = rm;
    speed_100 = sp;
    repeat (200) @(negedge core_clk);
    n = 0;
    while (ref_tick !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (ref_tick !== 1'b1 && n < 300);
    chk(16'(n), per);
    $display("t_tick done");
  endtask : t_tick

  task automatic conclude();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  // About 21 frames of 1344 cycles each; margin of about three quarters again
  initial begin
    #200000;
    fails++;
    conclude();
  end

  initial begin
    {rst, basic_isolate, coding_pulse_off, rmii_mode, speed_100} = 5'h10;
    an = '0;
    rx = '0;
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    t_reset(16'h0000);
    t_neg();
    t_iso();
    t_shadow();
    // Mid-run reset with results held; link pass level stays
    t_reset(16'h0080);
    t_tick(1'b0, 1'b0, 16'h0064);
    t_tick(1'b0, 1'b1, 16'h000A);
    t_tick(1'b1, 1'b0, 16'h0005);
    conclude();
  end
endmodule : pasr_regs_tb
`default_nettype wire
